// ==== verilog/tps_timer.sv ====
// How it works
// - Prescaler divides by powers of two, sixteen choices
// - Prescaler count is never visible to software
// - Prescaler clears on low byte, control writes, reset
// - Postscaler divides events by one through sixteen
// - Postscaler clears on same writes and reset
// - Synchronous mode halts counting during sleep
// - Asynchronous mode keeps counting, may wake system
// - Event on 8-bit compare match or 16-bit rollover
// - Flag sets every postscale-plus-one events
// - Enabled flag requests interrupt and wake
// - Output goes to pins, peripherals, status bit
// - Pulse lasts one prescaled period per postscaled event
// - Output toggles on each pulse rising edge
module tps_timer
   import tps_pkg::*;
(
   input  wire logic            mclk,
   input  wire logic            rst,
   input  wire tps_bus_req_type bus_req,
   output tps_bus_rsp_type      bus_rsp,
   input  wire logic            ext_clk_pin,
   input  wire logic            sleep,
   output logic                 timer_out,
   output logic                 internal_output_pulse,
   output logic                 irq_req,
   output logic                 wake_req
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        ext_sync1;
      logic        ext_sync2;
      logic        ext_prev;
      logic [7:0]  count_low_byte;
      logic [7:0]  compare_high_byte;
      logic        enable;
      logic        mode16;
      logic [3:0]  postscale_select;
      logic        ext_source;
      logic        sync_mode;
      logic [3:0]  prescale_select;
      logic        timer_event_flag;
      logic        timer_irq_enable;
      logic        pulse;
      logic        out;
      logic        ack;
      logic [31:0] readdata;
   } tps_state_type;

   tps_state_type st_ff;
   tps_state_type nxt_st;

   logic        ext_rise;
   logic        run;
   logic        src_tick;
   logic        pre_tick;
   logic        tmr_evt;
   logic        post_evt;
   logic        bus_req_on;
   logic        wr_acc;
   logic        rd_start;
   logic        cfg_clear;
   logic        flag_clr;
   logic [15:0] count16;
   logic [31:0] rd_mux;

   // ----------------------------------------------------------------
   // Scalers
   // ----------------------------------------------------------------
   tps_prescaler u_pre (
      .mclk     (mclk),
      .rst      (rst),
      .clear    (cfg_clear),
      .sel      (st_ff.prescale_select),
      .tick_in  (src_tick),
      .tick_out (pre_tick)
   );

   tps_postscaler u_post (
      .mclk      (mclk),
      .rst       (rst),
      .clear     (cfg_clear),
      .sel       (st_ff.postscale_select),
      .event_in  (tmr_evt),
      .event_out (post_evt)
   );

   // ----------------------------------------------------------------
   // Bus handshake: every access takes one wait cycle
   // ----------------------------------------------------------------
   // One forced wait lets read data come from a flip-flop
   assign bus_req_on = bus_req.read | bus_req.write;
   assign wr_acc     = bus_req.write & st_ff.ack;
   assign rd_start   = bus_req.read & ~st_ff.ack;
   assign bus_rsp.waitrequest = bus_req_on & ~st_ff.ack;
   assign bus_rsp.readdata    = st_ff.readdata;

   // Writes that restart both scalers
   assign cfg_clear = wr_acc & ((bus_req.address == TPS_ADDR_COUNT_LOW) |
                                (bus_req.address == TPS_ADDR_CTRL_FIRST) |
                                (bus_req.address == TPS_ADDR_CTRL_SECOND));
   assign flag_clr  = wr_acc & (bus_req.address == TPS_ADDR_IRQ) &
                      bus_req.writedata[TPS_IRQ_FLAG_BIT];

   // ----------------------------------------------------------------
   // Read mux; scaler counts are deliberately absent
   // ----------------------------------------------------------------
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (bus_req.address == TPS_ADDR_COUNT_LOW)
      begin
         rd_mux[7:0] = st_ff.count_low_byte;
      end
      else if (bus_req.address == TPS_ADDR_COMPARE_HI)
      begin
         rd_mux[7:0] = st_ff.compare_high_byte;
      end
      else if (bus_req.address == TPS_ADDR_CTRL_FIRST)
      begin
         rd_mux[TPS_CTRL0_EN_BIT]     = st_ff.enable;
         rd_mux[TPS_CTRL0_OUT_BIT]    = st_ff.out;
         rd_mux[TPS_CTRL0_MODE16_BIT] = st_ff.mode16;
         rd_mux[3:0]                  = st_ff.postscale_select;
      end
      else if (bus_req.address == TPS_ADDR_CTRL_SECOND)
      begin
         rd_mux[TPS_CTRL1_EXT_BIT]  = st_ff.ext_source;
         rd_mux[TPS_CTRL1_SYNC_BIT] = st_ff.sync_mode;
         rd_mux[3:0]                = st_ff.prescale_select;
      end
      else if (bus_req.address == TPS_ADDR_IRQ)
      begin
         rd_mux[TPS_IRQ_FLAG_BIT] = st_ff.timer_event_flag;
         rd_mux[TPS_IRQ_IE_BIT]   = st_ff.timer_irq_enable;
      end
   end

   // ----------------------------------------------------------------
   // Counting source and timer events
   // ----------------------------------------------------------------
   // Edge detect reads only the second synchroniser stage
   assign ext_rise = st_ff.ext_sync2 & ~st_ff.ext_prev;
   // A synchronous timer freezes in sleep; an asynchronous one keeps going
   assign run      = st_ff.enable & ~(sleep & st_ff.sync_mode);
   assign src_tick = run & (st_ff.ext_source ? ext_rise : 1'b1);
   assign count16  = {st_ff.compare_high_byte, st_ff.count_low_byte};
   assign tmr_evt  = pre_tick & (st_ff.mode16 ? (count16 == TPS_ROLL_VALUE) :
                     (st_ff.count_low_byte == st_ff.compare_high_byte));

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.ext_sync1 = ext_clk_pin;
      nxt_st.ext_sync2 = st_ff.ext_sync1;
      nxt_st.ext_prev  = st_ff.ext_sync2;
      nxt_st.ack       = bus_req_on & ~st_ff.ack;

      // Timer advance on every completed prescale division
      if (pre_tick)
      begin
         if (st_ff.mode16)
         begin
            {nxt_st.compare_high_byte, nxt_st.count_low_byte} =
               16'(count16 + 16'h0001);
         end
         else if (tmr_evt)
         begin
            nxt_st.count_low_byte = 8'h00;
         end
         else
         begin
            nxt_st.count_low_byte = 8'(st_ff.count_low_byte + 8'h01);
         end
      end

      // Pulse holds until the next prescaled tick: one prescaled period
      if (post_evt)
      begin
         nxt_st.pulse = 1'b1;
      end
      else if (pre_tick)
      begin
         nxt_st.pulse = 1'b0;
      end
      if (post_evt && !st_ff.pulse)
      begin
         nxt_st.out = ~st_ff.out;
      end

      // Set wins over a clear in the same cycle
      nxt_st.timer_event_flag = (st_ff.timer_event_flag & ~flag_clr) | post_evt;

      // Register writes take priority over counting
      if (wr_acc)
      begin
         if (bus_req.address == TPS_ADDR_COUNT_LOW)
         begin
            nxt_st.count_low_byte = bus_req.writedata[7:0];
         end
         else if (bus_req.address == TPS_ADDR_COMPARE_HI)
         begin
            nxt_st.compare_high_byte = bus_req.writedata[7:0];
         end
         else if (bus_req.address == TPS_ADDR_CTRL_FIRST)
         begin
            nxt_st.enable           = bus_req.writedata[TPS_CTRL0_EN_BIT];
            nxt_st.mode16           = bus_req.writedata[TPS_CTRL0_MODE16_BIT];
            nxt_st.postscale_select = bus_req.writedata[3:0];
         end
         else if (bus_req.address == TPS_ADDR_CTRL_SECOND)
         begin
            nxt_st.ext_source      = bus_req.writedata[TPS_CTRL1_EXT_BIT];
            nxt_st.sync_mode       = bus_req.writedata[TPS_CTRL1_SYNC_BIT];
            nxt_st.prescale_select = bus_req.writedata[3:0];
         end
         else if (bus_req.address == TPS_ADDR_IRQ)
         begin
            nxt_st.timer_irq_enable = bus_req.writedata[TPS_IRQ_IE_BIT];
         end
      end

      if (rd_start)
      begin
         nxt_st.readdata = rd_mux;
      end
   end

   // State register
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         st_ff                   <= '0;
         st_ff.count_low_byte    <= TPS_LOW_RST;
         st_ff.compare_high_byte <= TPS_COMPARE_RST;
         st_ff.postscale_select  <= TPS_SEL_RST;
         st_ff.prescale_select   <= TPS_SEL_RST;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign timer_out             = st_ff.out;
   assign internal_output_pulse = st_ff.pulse;
   assign irq_req  = st_ff.timer_event_flag & st_ff.timer_irq_enable;
   assign wake_req = irq_req & sleep;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_flag_on_event: assert property (@(posedge mclk) disable iff (rst)
      post_evt |=> st_ff.timer_event_flag)
      else $error("event flag missed a postscaled event");

   a_sleep_halt: assert property (@(posedge mclk) disable iff (rst)
      (sleep && st_ff.sync_mode && !wr_acc) |=> $stable(count16))
      else $error("synchronous timer counted in sleep");

   a_async_sleep_run: assert property (@(posedge mclk) disable iff (rst)
      (sleep && !st_ff.sync_mode && st_ff.enable && st_ff.ext_source && ext_rise &&
       st_ff.prescale_select == 4'h0 && !st_ff.mode16 && !wr_acc &&
       st_ff.count_low_byte != st_ff.compare_high_byte)
      |=> st_ff.count_low_byte == 8'($past(st_ff.count_low_byte) + 8'h01))
      else $error("asynchronous timer stalled in sleep");

   a_match_reset: assert property (@(posedge mclk) disable iff (rst)
      (!st_ff.mode16 && pre_tick && !wr_acc &&
       st_ff.count_low_byte == st_ff.compare_high_byte) |=> st_ff.count_low_byte == 8'h00)
      else $error("8-bit match did not restart count");

   a_pulse_start: assert property (@(posedge mclk) disable iff (rst)
      post_evt |=> st_ff.pulse)
      else $error("output pulse missing after event");

   a_out_toggle: assert property (@(posedge mclk) disable iff (rst)
      $rose(st_ff.pulse) |-> st_ff.out != $past(st_ff.out))
      else $error("output did not toggle on pulse edge");

   a_irq_wake: assert property (@(posedge mclk) disable iff (rst)
      (post_evt && st_ff.timer_irq_enable && sleep && !wr_acc) ##1 sleep |-> wake_req)
      else $error("enabled event did not raise wake");

   a_bus_answer: assert property (@(posedge mclk) disable iff (rst)
      (bus_req_on && bus_rsp.waitrequest) |=> (!bus_req_on || !bus_rsp.waitrequest))
      else $error("bus access not answered in two cycles");

endmodule

// ==== verilog/tps_pkg.sv ====
package tps_pkg;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [4:0] TPS_ADDR_COUNT_LOW   = 5'h00;
   localparam logic [4:0] TPS_ADDR_COMPARE_HI  = 5'h04;
   localparam logic [4:0] TPS_ADDR_CTRL_FIRST  = 5'h08;
   localparam logic [4:0] TPS_ADDR_CTRL_SECOND = 5'h0c;
   localparam logic [4:0] TPS_ADDR_IRQ         = 5'h10;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int TPS_CTRL0_EN_BIT     = 7;
   localparam int TPS_CTRL0_OUT_BIT    = 5;
   localparam int TPS_CTRL0_MODE16_BIT = 4;
   localparam int TPS_CTRL1_EXT_BIT    = 5;
   localparam int TPS_CTRL1_SYNC_BIT   = 4;
   localparam int TPS_IRQ_FLAG_BIT     = 0;
   localparam int TPS_IRQ_IE_BIT       = 1;

   // ----------------------------------------------------------------
   // Reset values and counts
   // ----------------------------------------------------------------
   localparam logic [7:0]  TPS_COMPARE_RST = 8'hff;
   localparam logic [7:0]  TPS_LOW_RST     = 8'h00;
   localparam logic [15:0] TPS_ROLL_VALUE  = 16'hffff;
   localparam logic [3:0]  TPS_SEL_RST     = 4'h0;

   // ----------------------------------------------------------------
   // Bus carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        read;
      logic        write;
      logic [4:0]  address;
      logic [31:0] writedata;
   } tps_bus_req_type;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } tps_bus_rsp_type;

endpackage

// ==== verilog/tps_prescaler.sv ====
module tps_prescaler
   import tps_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       clear,
   input  wire logic [3:0] sel,
   input  wire logic       tick_in,
   output logic            tick_out
);

   typedef struct packed {
      logic [14:0] cnt;
   } tps_pre_state_type;

   tps_pre_state_type st_ff;
   tps_pre_state_type nxt_st;
   logic [14:0]       term;

   // ----------------------------------------------------------------
   // Power-of-two divider, count hidden from software
   // ----------------------------------------------------------------
   // Terminal count is 2^sel - 1; sel 15 gives 1:32768
   always_comb
   begin
      term = 15'((16'h0001 << sel) - 16'h0001);
      tick_out = tick_in & (st_ff.cnt == term);
      nxt_st = st_ff;
      if (clear)
      begin
         nxt_st.cnt = 15'h0000;
      end
      else if (tick_in)
      begin
         nxt_st.cnt = (st_ff.cnt == term) ? 15'h0000 : 15'(st_ff.cnt + 15'h0001);
      end
   end

   // Count state
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   a_prescale_clear: assert property (@(posedge mclk) disable iff (rst)
      clear |=> st_ff.cnt == 15'h0000)
      else $error("prescaler not cleared");

   a_prescale_wrap: assert property (@(posedge mclk) disable iff (rst)
      (tick_in && !clear && st_ff.cnt == term) |=> st_ff.cnt == 15'h0000)
      else $error("prescaler did not wrap at terminal count");

endmodule

// ==== verilog/tps_postscaler.sv ====
module tps_postscaler
   import tps_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       clear,
   input  wire logic [3:0] sel,
   input  wire logic       event_in,
   output logic            event_out
);

   typedef struct packed {
      logic [3:0] cnt;
   } tps_post_state_type;

   tps_post_state_type st_ff;
   tps_post_state_type nxt_st;

   // ----------------------------------------------------------------
   // Divide timer events by sel + 1
   // ----------------------------------------------------------------
   always_comb
   begin
      event_out = event_in & (st_ff.cnt == sel);
      nxt_st = st_ff;
      if (clear)
      begin
         nxt_st.cnt = 4'h0;
      end
      else if (event_in)
      begin
         nxt_st.cnt = (st_ff.cnt == sel) ? 4'h0 : 4'(st_ff.cnt + 4'h1);
      end
   end

   // Count state, hidden from software
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   a_postscale_clear: assert property (@(posedge mclk) disable iff (rst)
      clear |=> st_ff.cnt == 4'h0)
      else $error("postscaler not cleared");

endmodule

// ==== bench/tps_consumer.sv ====
// ------------------------------------------------------------
// Consumer of the timer output, as a peripheral would see it
// ------------------------------------------------------------
module tps_consumer
(
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic timer_out,
   input  wire logic internal_output_pulse,
   output int        rise_cnt,
   output int        tog_cnt,
   output int        gap,
   output int        width
);
   timeunit 1ns;
   timeprecision 100ps;

   int   cyc;
   int   last_rise;
   int   hi_start;
   logic pulse_q;
   logic out_q;

   // Time pulse edges in clock cycles; only edges matter to a trigger input
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         cyc = 0;
         rise_cnt = 0;
         tog_cnt = 0;
         gap = 0;
         width = 0;
         last_rise = 0;
         hi_start = 0;
         pulse_q = 1'b0;
         out_q = 1'b0;
      end
      else
      begin
         cyc++;
         if (internal_output_pulse === 1'b1 && pulse_q === 1'b0)
         begin
            rise_cnt++;
            gap = cyc - last_rise;
            last_rise = cyc;
            hi_start = cyc;
         end
         if (internal_output_pulse === 1'b0 && pulse_q === 1'b1)
            width = cyc - hi_start;
         if (timer_out !== out_q)
            tog_cnt++;
         pulse_q = internal_output_pulse;
         out_q = timer_out;
      end
   end
endmodule

// ==== bench/tb_top.sv ====
module tb_top import tps_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic            mclk, rst, ext_clk_pin, sleep;
   tps_bus_req_type req;
   tps_bus_rsp_type rsp;
   logic            timer_out, pulse, irq_req, wake_req;
   int              rise_cnt, tog_cnt, gap, width;
   int              failures, compares, r0, t0;
   logic [7:0]      q;

   tps_timer uut (.mclk(mclk), .rst(rst), .bus_req(req), .bus_rsp(rsp),
      .ext_clk_pin(ext_clk_pin), .sleep(sleep), .timer_out(timer_out),
      .internal_output_pulse(pulse), .irq_req(irq_req), .wake_req(wake_req));

   tps_consumer peer (.mclk(mclk), .rst(rst), .timer_out(timer_out),
      .internal_output_pulse(pulse), .rise_cnt(rise_cnt), .tog_cnt(tog_cnt),
      .gap(gap), .width(width));

   // ------------------------------------------------------------
   // Clock, reporting and bus helpers
   // ------------------------------------------------------------
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic final_report();
      $display("Counts: %0d compares, %0d failures", compares, failures);
      if (failures == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic fail(input string m);
      failures++;
      $display("[ERR] %0t %s", $time, m);
   endtask

   task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string m);
      compares++;
      if (got !== exp)
         fail($sformatf("%s got %h exp %h", m, got, exp));
   endtask

   task automatic checkn(input int got, input int exp, input string m);
      compares++;
      if (got != exp)
         fail($sformatf("%s got %0d exp %0d", m, got, exp));
   endtask

   // Request held until waitrequest is seen low; only the watchdog ends a wait
   task automatic bus(input logic wr_en, input logic [4:0] a, input logic [7:0] d,
                      output logic [7:0] rq);
      @(posedge mclk);
      req.read <= ~wr_en;
      req.write <= wr_en;
      req.address <= a;
      req.writedata <= {24'h000000, d};
      @(posedge mclk);
      while (rsp.waitrequest !== 1'b0)
      begin
         @(posedge mclk);
      end
      rq = rsp.readdata[7:0];
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] dummy;
      bus(1'b1, a, d, dummy);
   endtask

   task automatic rd(input logic [4:0] a, output logic [7:0] rq);
      bus(1'b0, a, 8'h00, rq);
   endtask

   // Stop, set the prescaler, zero the count, then start with c1
   task automatic cfg(input logic [7:0] c2, input logic [7:0] c1);
      wr(TPS_ADDR_CTRL_FIRST, 8'h00);
      wr(TPS_ADDR_CTRL_SECOND, c2);
      wr(TPS_ADDR_COUNT_LOW, 8'h00);
      wr(TPS_ADDR_CTRL_FIRST, c1);
   endtask

   task automatic wait_rises(input int k, input int lim);
      int n, s;
      s = rise_cnt;
      n = 0;
      // Falling edge: the consumer has finished its update for this cycle
      while (rise_cnt < s + k && n < lim)
      begin
         @(negedge mclk);
         n++;
      end
      if (rise_cnt < s + k)
         fail("pulse missing");
   endtask

   task automatic pins(input int n);
      repeat (n)
      begin
         @(posedge mclk);
         ext_clk_pin <= 1'b1;
         repeat (4) @(posedge mclk);
         ext_clk_pin <= 1'b0;
         repeat (4) @(posedge mclk);
      end
   endtask

   // Watchdog well beyond the roughly 20k cycles the tests need
   initial
   begin
      #(60000 * 40);
      fail("timeout");
      final_report();
   end

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial
   begin
      rst = 1'b1;
      ext_clk_pin = 1'b0;
      sleep = 1'b0;
      req = '0;
      failures = 0;
      compares = 0;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      rd(TPS_ADDR_COUNT_LOW, q);
      check8(q, TPS_LOW_RST, "low rst");
      rd(TPS_ADDR_COMPARE_HI, q);
      check8(q, TPS_COMPARE_RST, "cmp rst");
      rd(TPS_ADDR_CTRL_FIRST, q);
      check8(q, 8'h00, "ctl1 rst");
      rd(TPS_ADDR_CTRL_SECOND, q);
      check8(q, 8'h00, "ctl2 rst");
      rd(TPS_ADDR_IRQ, q);
      check8(q, 8'h00, "irq rst");
      wr(5'h14, 8'h5a);
      rd(5'h14, q);
      check8(q, 8'h00, "unmapped");
      rd(TPS_ADDR_COMPARE_HI, q);
      check8(q, TPS_COMPARE_RST, "cmp kept");
      $display("test reset done");
      // Prescale ratios 2^s, compare 1 gives an event every second tick
      wr(TPS_ADDR_COMPARE_HI, 8'h01);
      for (int s = 0; s < 12; s++)
      begin
         cfg(8'(s), 8'h80);
         r0 = rise_cnt;
         t0 = tog_cnt;
         wait_rises(2, 8 * (2 ** s) + 40);
         checkn(gap, 2 ** (s + 1), "presc gap");
         checkn(width, 2 ** s, "pulse width");
         checkn(tog_cnt - t0, rise_cnt - r0, "toggles");
      end
      $display("test prescaler done");
      for (int p = 0; p < 16; p++)
      begin
         cfg(8'h00, 8'h80 | 8'(p));
         wait_rises(2, 8 * (p + 1) + 40);
         checkn(gap, 2 * (p + 1), "postsc gap");
         checkn(width, 1, "post width");
      end
      $display("test postscaler done");
      // Control writes every 13 cycles keep a 1:16 postscaler from firing
      cfg(8'h00, 8'h8f);
      wr(TPS_ADDR_IRQ, 8'h01);
      repeat (8)
      begin
         repeat (10) @(posedge mclk);
         wr(TPS_ADDR_CTRL_FIRST, 8'h8f);
      end
      rd(TPS_ADDR_IRQ, q);
      check8(q, 8'h00, "post cleared");
      repeat (40) @(posedge mclk);
      rd(TPS_ADDR_IRQ, q);
      check8(q, 8'h01, "post fires");
      $display("test postscaler clear done");
      // 16-bit rollover, then flag, enable and wake
      wr(TPS_ADDR_CTRL_FIRST, 8'h00);
      wr(TPS_ADDR_CTRL_SECOND, 8'h00);
      wr(TPS_ADDR_COMPARE_HI, 8'hff);
      wr(TPS_ADDR_COUNT_LOW, 8'hfd);
      wr(TPS_ADDR_IRQ, 8'h01);
      wr(TPS_ADDR_CTRL_FIRST, 8'h90);
      wait_rises(1, 20);
      wr(TPS_ADDR_CTRL_FIRST, 8'h10);
      rd(TPS_ADDR_COMPARE_HI, q);
      check8(q, 8'h00, "rollover");
      rd(TPS_ADDR_IRQ, q);
      check8(q, 8'h01, "flag set");
      @(negedge mclk);
      check8(irq_req, 1'b0, "irq masked");
      wr(TPS_ADDR_IRQ, 8'h02);
      @(negedge mclk);
      check8(irq_req, 1'b1, "irq on");
      @(posedge mclk);
      sleep <= 1'b1;
      @(negedge mclk);
      check8(wake_req, 1'b1, "wake");
      @(posedge mclk);
      sleep <= 1'b0;
      wr(TPS_ADDR_IRQ, 8'h03);
      rd(TPS_ADDR_IRQ, q);
      check8(q, 8'h02, "flag clr");
      @(negedge mclk);
      check8(irq_req, 1'b0, "irq off");
      wr(TPS_ADDR_IRQ, 8'h00);
      rd(TPS_ADDR_CTRL_FIRST, q);
      check8(q[TPS_CTRL0_OUT_BIT], tog_cnt[0], "out mirror");
      $display("test event and irq done");
      // The rollover left compare at 00, which would pin an 8-bit count at 0
      wr(TPS_ADDR_COMPARE_HI, 8'hff);
      // Second-control writes every 13 cycles keep a 1:16 prescaler idle
      cfg(8'h04, 8'h80);
      repeat (8)
      begin
         repeat (10) @(posedge mclk);
         wr(TPS_ADDR_CTRL_SECOND, 8'h04);
      end
      rd(TPS_ADDR_COUNT_LOW, q);
      check8(q, 8'h00, "presc cleared");
      repeat (40) @(posedge mclk);
      rd(TPS_ADDR_COUNT_LOW, q);
      check8(q != 8'h00, 1'b1, "presc runs");
      $display("test prescaler clear done");
      // Sleep: synchronous halts, asynchronous pin edges still count
      wr(TPS_ADDR_CTRL_FIRST, 8'h00);
      wr(TPS_ADDR_CTRL_SECOND, 8'h10);
      wr(TPS_ADDR_COUNT_LOW, 8'h00);
      @(posedge mclk);
      sleep <= 1'b1;
      wr(TPS_ADDR_CTRL_FIRST, 8'h80);
      repeat (20) @(posedge mclk);
      rd(TPS_ADDR_COUNT_LOW, q);
      check8(q, 8'h00, "sync sleep");
      @(posedge mclk);
      sleep <= 1'b0;
      repeat (10) @(posedge mclk);
      rd(TPS_ADDR_COUNT_LOW, q);
      check8(q != 8'h00, 1'b1, "awake");
      cfg(8'h20, 8'h80);
      @(posedge mclk);
      sleep <= 1'b1;
      pins(5);
      rd(TPS_ADDR_COUNT_LOW, q);
      check8(q, 8'h05, "async sleep");
      wr(TPS_ADDR_CTRL_SECOND, 8'h30);
      pins(3);
      rd(TPS_ADDR_COUNT_LOW, q);
      check8(q, 8'h05, "ext sync halt");
      @(posedge mclk);
      sleep <= 1'b0;
      $display("test sleep done");
      final_report();
   end
endmodule
